//--- logic/brlp_pkg.sv
// constants and types for the boot, reset and low-power controller
// assumes a single 100 MHz system clock feeding every register
package brlp_pkg;

  // system clock
  localparam real CLK_MHZ = 100.0;

  // rom boot watch window on the serial port, in seconds
  localparam real BOOT_WATCH_S = 1.4;
  localparam int BOOT_WATCH_CYC = int'(BOOT_WATCH_S * CLK_MHZ * 1.0e6);
  localparam int BOOT_CNT_W = 28;

  // slow clock rates, in kHz, and their periods in system cycles
  localparam real SLOW_FAST_KHZ = 32.0;
  localparam real SLOW_LOW_KHZ = 3.2;
  localparam int SLOW_FAST_CYC = int'(CLK_MHZ * 1.0e3 / SLOW_FAST_KHZ);
  localparam int SLOW_LOW_CYC = int'(CLK_MHZ * 1.0e3 / SLOW_LOW_KHZ);
  // no edge within two slow periods means the slow clock is absent
  localparam int SLOW_ABSENT_CYC = 2 * SLOW_LOW_CYC;
  localparam int DET_CNT_W = 17;
  // detection windows are one eighth of the period either side
  localparam int DET_TOL_SHIFT = 3;

  // internal 32 kHz divider from the system clock
  localparam logic [11:0] DIV_LAST = 12'(SLOW_FAST_CYC - 1);
  localparam logic [11:0] DIV_ZERO = 12'h000;

  // wake source layout: gpios first, then the fixed sources
  localparam int GPIO_N = 16;
  localparam int WAKE_USB = 16;
  localparam int WAKE_DBG_RX = 17;
  localparam int WAKE_HOST_RX = 18;
  localparam int WAKE_IRQ_A = 19;
  localparam int WAKE_IRQ_B = 20;
  localparam int WAKE_N = 21;

  localparam logic [15:0] ANCHOR_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    BOOT_RESET,
    BOOT_ROM_WATCH,
    BOOT_ROM_LOAD,
    BOOT_FLASH
  } brlp_boot_e;

  typedef enum logic [1:0] {
    LP_ACTIVE,
    LP_SLEEP,
    LP_DEEP,
    LP_DEEP_XCHG
  } brlp_lp_e;

  typedef enum logic [1:0] {
    SLOW_NONE,
    SLOW_EXT32,
    SLOW_EXT3K2
  } brlp_rate_e;

  typedef enum logic [1:0] {
    SRC_XTAL,
    SRC_EXT32,
    SRC_EXT3K2,
    SRC_DIV
  } brlp_src_e;

endpackage : brlp_pkg

//--- logic/brlp_ctrl.sv
// boot source, reset, slow clock and low-power mode controller
// assumes all inputs synchronous to clk; clock gating is done outside
// from the enables driven here
`timescale 1ns/1ps
module brlp_ctrl #(
  parameter int BOOT_WATCH_CYC = brlp_pkg::BOOT_WATCH_CYC,
  parameter int SLOW_LOW_CYC = brlp_pkg::SLOW_LOW_CYC,
  parameter int SLOW_ABSENT_CYC = brlp_pkg::SLOW_ABSENT_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic boot_strap_in,
  input wire logic download_req_in,
  input wire logic download_done_in,
  input wire logic debug_tx_data_in,
  input wire logic host_tx_data_in,
  input wire logic debug_serial_rx_in,
  input wire logic host_serial_rx_in,
  input wire logic ext_irq_line_a,
  input wire logic ext_irq_line_b,
  input wire logic usb_wake_in,
  input wire logic [brlp_pkg::GPIO_N-1:0] gpio_in,
  input wire logic [brlp_pkg::GPIO_N-1:0] gpio_wake_en_in,
  input wire logic [brlp_pkg::GPIO_N-1:0] gpio_irq_en_in,
  input wire logic slow_clk_in,
  input wire logic xtal_clk_in,
  input wire logic sysclk_always_on_in,
  input wire logic usb_transport_in,
  input wire logic link_active_in,
  input wire logic sniff_park_in,
  input wire logic scan_enabled_in,
  input wire logic sched_idle_in,
  input wire logic host_link_lowpower_in,
  input wire logic exchange_done_in,
  input wire logic [15:0] anchor_interval_in,
  output logic debug_serial_tx_out,
  output logic debug_serial_tx_oe,
  output logic host_serial_tx_out,
  output logic host_serial_tx_oe,
  output logic fetch_en,
  output logic run_from_flash,
  output logic run_from_rom,
  output brlp_pkg::brlp_rate_e slow_rate,
  output brlp_pkg::brlp_src_e slow_src,
  output logic slow_tick,
  output logic [brlp_pkg::GPIO_N-1:0] gpio_irq,
  output logic sleep_mode,
  output logic deep_sleep_mode,
  output logic sysclk_req,
  output logic core_clk_en,
  output logic host_cmd_accept,
  output logic link_data_en
);
  import brlp_pkg::*;

  // every check below samples on clk and sleeps through reset
  default clocking cb_sys @(posedge clk); endclocking
  default disable iff (sys_rst);

  brlp_boot_e boot_ff;
  brlp_lp_e lp_ff;
  brlp_rate_e rate_ff;
  brlp_src_e src_ff;
  logic strap_ff;
  logic [BOOT_CNT_W-1:0] boot_cnt_ff;
  logic dbg_tx_ff, host_tx_ff, tx_oe_ff;
  logic fetch_ff, flash_ff, rom_ff;
  logic slow_prev_ff, xtal_prev_ff, tick_ff;
  logic [DET_CNT_W-1:0] per_cnt_ff;
  logic [11:0] div_ff;
  logic [WAKE_N-1:0] wake_prev_ff;
  logic wake_arm_ff;
  logic [WAKE_N-1:0] wake_now;
  logic [WAKE_N-1:0] wake_hit;
  logic [GPIO_N-1:0] gpio_irq_ff;
  logic [15:0] anchor_ff;
  logic anchor_due;
  logic any_wake, host_wake, deep_ok;
  logic slow_rise, xtal_rise, div_wrap;
  logic sleep_ff, deep_ff, clkreq_ff, core_en_ff, cmd_ff, data_ff;

  // detection limits sized to the period counter; BOOT_LAST sized to the boot counter
  localparam logic [DET_CNT_W-1:0] FAST_P = DET_CNT_W'(SLOW_FAST_CYC);
  localparam logic [DET_CNT_W-1:0] LOW_P = DET_CNT_W'(SLOW_LOW_CYC);
  localparam logic [DET_CNT_W-1:0] ABSENT_P = DET_CNT_W'(SLOW_ABSENT_CYC);
  localparam logic [DET_CNT_W-1:0] FAST_TOL = FAST_P >> DET_TOL_SHIFT;
  localparam logic [DET_CNT_W-1:0] LOW_TOL = LOW_P >> DET_TOL_SHIFT;
  localparam logic [BOOT_CNT_W-1:0] BOOT_LAST =
    BOOT_CNT_W'(BOOT_WATCH_CYC - 1);

  // boot sequencer: async reset holds the defaults so the first fetch
  // sees them; strap is caught on the first edge after release
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      boot_ff <= BOOT_RESET;
      strap_ff <= 1'b0;
      boot_cnt_ff <= '0;
    end else begin
      case (boot_ff)
        BOOT_RESET: begin
          strap_ff <= boot_strap_in;
          boot_cnt_ff <= '0;
          boot_ff <= boot_strap_in ? BOOT_FLASH : BOOT_ROM_WATCH;
        end
        BOOT_ROM_WATCH: begin
          boot_cnt_ff <= boot_cnt_ff + 1'b1;
          if (download_req_in) begin
            boot_ff <= BOOT_ROM_LOAD;
          end else if (boot_cnt_ff == BOOT_LAST) begin
            boot_ff <= BOOT_FLASH;
          end
        end
        BOOT_ROM_LOAD: begin
          // a download ends only by the loader or a new reset
          if (download_done_in) begin
            boot_ff <= BOOT_FLASH;
          end
        end
        BOOT_FLASH: boot_ff <= BOOT_FLASH;
        default: boot_ff <= BOOT_RESET;
      endcase
    end
  end

  // boot outputs and serial pins; oe stays low until the sequencer
  // has left its reset state, so no glitch drives the host line
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_oe_ff <= 1'b0;
      dbg_tx_ff <= 1'b1;
      host_tx_ff <= 1'b1;
      fetch_ff <= 1'b0;
      flash_ff <= 1'b0;
      rom_ff <= 1'b0;
    end else begin
      tx_oe_ff <= (boot_ff != BOOT_RESET);
      dbg_tx_ff <= debug_tx_data_in;
      host_tx_ff <= host_tx_data_in;
      fetch_ff <= (boot_ff != BOOT_RESET);
      flash_ff <= (boot_ff == BOOT_FLASH);
      rom_ff <= (boot_ff == BOOT_ROM_WATCH) || (boot_ff == BOOT_ROM_LOAD);
    end
  end

  // slow clock edge detectors and internal divider
  assign slow_rise = slow_clk_in && !slow_prev_ff;
  assign xtal_rise = xtal_clk_in && !xtal_prev_ff;
  assign div_wrap = (div_ff == DIV_LAST);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slow_prev_ff <= 1'b0;
      xtal_prev_ff <= 1'b0;
      div_ff <= DIV_ZERO;
    end else begin
      slow_prev_ff <= slow_clk_in;
      xtal_prev_ff <= xtal_clk_in;
      div_ff <= div_wrap ? DIV_ZERO : div_ff + 1'b1;
    end
  end

  // period measurement; a single stray period reclassifies, which
  // trades noise immunity for a fast answer after a clock change
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      per_cnt_ff <= '0;
      rate_ff <= SLOW_NONE;
    end else if (slow_rise) begin
      per_cnt_ff <= '0;
      if (per_cnt_ff >= FAST_P - FAST_TOL &&
          per_cnt_ff <= FAST_P + FAST_TOL) begin
        rate_ff <= SLOW_EXT32;
      end else if (per_cnt_ff >= LOW_P - LOW_TOL &&
                   per_cnt_ff <= LOW_P + LOW_TOL) begin
        rate_ff <= SLOW_EXT3K2;
      end else begin
        rate_ff <= SLOW_NONE;
      end
    end else if (per_cnt_ff >= ABSENT_P) begin
      rate_ff <= SLOW_NONE;
    end else begin
      per_cnt_ff <= per_cnt_ff + 1'b1;
    end
  end

  // reference selection and the tick that paces low-power logic
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      src_ff <= SRC_XTAL;
      tick_ff <= 1'b0;
    end else begin
      case (rate_ff)
        SLOW_EXT32: src_ff <= SRC_EXT32;
        SLOW_EXT3K2: src_ff <= SRC_EXT3K2;
        default: src_ff <= sysclk_always_on_in ? SRC_DIV : SRC_XTAL;
      endcase
      case (src_ff)
        SRC_EXT32, SRC_EXT3K2: tick_ff <= slow_rise;
        SRC_DIV: tick_ff <= div_wrap;
        default: tick_ff <= xtal_rise;
      endcase
    end
  end

  // wake sources: gpios only when enabled, the rest always
  assign wake_now = {ext_irq_line_b, ext_irq_line_a, host_serial_rx_in,
                     debug_serial_rx_in, usb_wake_in, gpio_in};

  generate
    for (genvar i = 0; i < WAKE_N; i++) begin : g_wake
      if (i < GPIO_N) begin : g_gpio
        // any gpio edge wakes or interrupts
        assign wake_hit[i] = gpio_wake_en_in[i] && wake_arm_ff &&
                             (wake_now[i] != wake_prev_ff[i]);
        always_ff @(posedge clk or posedge sys_rst) begin
          if (sys_rst) begin
            gpio_irq_ff[i] <= 1'b0;
          end else begin
            gpio_irq_ff[i] <= gpio_irq_en_in[i] && wake_arm_ff &&
                              (wake_now[i] != wake_prev_ff[i]);
          end
        end
      end else if (i == WAKE_DBG_RX || i == WAKE_HOST_RX) begin : g_rx
        // serial lines idle high; a start bit falls
        assign wake_hit[i] = wake_prev_ff[i] && !wake_now[i];
      end else begin : g_lvl
        assign wake_hit[i] = wake_now[i] && !wake_prev_ff[i];
      end
    end
  endgenerate

  // the reset pattern is only a guess at the gpio levels, so gpio
  // edges are ignored until one real sample has been taken
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_prev_ff <= {WAKE_N{1'b1}};
      wake_arm_ff <= 1'b0;
    end else begin
      wake_prev_ff <= wake_now;
      wake_arm_ff <= 1'b1;
    end
  end

  assign any_wake = |wake_hit;
  assign host_wake = wake_hit[WAKE_HOST_RX];

  // anchor scheduler counted in slow ticks, so it keeps time while
  // the system clock is gated; the interval is in ticks of the
  // selected reference and firmware scales it for 3.2 kHz
  assign anchor_due = tick_ff && (anchor_interval_in != ANCHOR_ZERO) &&
                      (sniff_park_in || scan_enabled_in) &&
                      (anchor_ff == anchor_interval_in - 1'b1);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      anchor_ff <= ANCHOR_ZERO;
    end else if (!(sniff_park_in || scan_enabled_in) || anchor_due) begin
      anchor_ff <= ANCHOR_ZERO;
    end else if (tick_ff) begin
      anchor_ff <= anchor_ff + 1'b1;
    end
  end

  // deep sleep needs a quiet host link, no usb and no live link
  assign deep_ok = host_link_lowpower_in && !usb_transport_in &&
                   !link_active_in;

  // mode machine: entry into low power waits for a slow tick, exits
  // are immediate, except that LP_DEEP_XCHG ignores every wake but the host one
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lp_ff <= LP_ACTIVE;
    end else begin
      case (lp_ff)
        LP_ACTIVE: begin
          if (boot_ff == BOOT_FLASH && tick_ff &&
              (sched_idle_in || sniff_park_in)) begin
            lp_ff <= LP_SLEEP;
          end
        end
        LP_SLEEP: begin
          if (any_wake || anchor_due || !sched_idle_in) begin
            lp_ff <= LP_ACTIVE;
          end else if (tick_ff && deep_ok) begin
            lp_ff <= LP_DEEP;
          end
        end
        LP_DEEP: begin
          if (host_wake || any_wake || !deep_ok) begin
            lp_ff <= LP_SLEEP;
          end else if (anchor_due) begin
            lp_ff <= LP_DEEP_XCHG;
          end
        end
        LP_DEEP_XCHG: begin
          if (host_wake || !deep_ok) begin
            lp_ff <= LP_SLEEP;
          end else if (exchange_done_in) begin
            lp_ff <= LP_DEEP;
          end
        end
        default: lp_ff <= LP_ACTIVE;
      endcase
    end
  end

  // clock and service enables decoded from the current mode
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_ff <= 1'b0;
      deep_ff <= 1'b0;
      clkreq_ff <= 1'b1;
      core_en_ff <= 1'b1;
      cmd_ff <= 1'b1;
      data_ff <= 1'b1;
    end else begin
      sleep_ff <= (lp_ff == LP_SLEEP);
      deep_ff <= (lp_ff == LP_DEEP);
      clkreq_ff <= (lp_ff != LP_DEEP);
      core_en_ff <= (lp_ff == LP_ACTIVE) || (lp_ff == LP_DEEP_XCHG);
      cmd_ff <= (lp_ff == LP_ACTIVE) || (lp_ff == LP_SLEEP);
      data_ff <= (lp_ff != LP_DEEP);
    end
  end

  assign debug_serial_tx_out = dbg_tx_ff;
  assign debug_serial_tx_oe = tx_oe_ff;
  assign host_serial_tx_out = host_tx_ff;
  assign host_serial_tx_oe = tx_oe_ff;
  assign fetch_en = fetch_ff;
  assign run_from_flash = flash_ff;
  assign run_from_rom = rom_ff;
  assign slow_rate = rate_ff;
  assign slow_src = src_ff;
  assign slow_tick = tick_ff;
  assign gpio_irq = gpio_irq_ff;
  assign sleep_mode = sleep_ff;
  assign deep_sleep_mode = deep_ff;
  assign sysclk_req = clkreq_ff;
  assign core_clk_en = core_en_ff;
  assign host_cmd_accept = cmd_ff;
  assign link_data_en = data_ff;

  // checks; the strap check skips the edge that loads the strap
  AST_TX_HIZ_AFTER_RST: assert property (
    $past(boot_ff) == BOOT_RESET |-> !host_serial_tx_oe && !debug_serial_tx_oe)
    else $error("serial tx driven straight after reset");
  AST_FLASH_BOOT: assert property (
    boot_ff == BOOT_RESET && boot_strap_in |=> ##1 run_from_flash)
    else $error("strap high did not start flash");
  AST_ROM_BOOT: assert property (
    boot_ff == BOOT_RESET && !boot_strap_in |=> ##1 run_from_rom)
    else $error("strap low did not start rom");
  AST_ROM_TIMEOUT: assert property (
    boot_ff == BOOT_ROM_WATCH && boot_cnt_ff == BOOT_LAST &&
    !download_req_in |=> boot_ff == BOOT_FLASH)
    else $error("rom watch did not jump to flash");
  AST_FETCH_AFTER_REL: assert property (
    boot_ff == BOOT_RESET |=> ##1 fetch_en)
    else $error("fetch not enabled after release");
  AST_STRAP_HELD: assert property (
    $past(boot_ff) != BOOT_RESET && boot_ff != BOOT_RESET |-> $stable(strap_ff))
    else $error("boot strap changed after release");
  AST_NO_DEEP_USB: assert property (
    usb_transport_in && lp_ff != LP_DEEP |=> lp_ff != LP_DEEP)
    else $error("deep sleep entered with usb transport");
  AST_NO_DEEP_LINK: assert property (
    link_active_in && lp_ff == LP_SLEEP |=> lp_ff != LP_DEEP)
    else $error("deep sleep entered with active link");
  AST_DEEP_REFUSES: assert property (
    lp_ff == LP_DEEP |=> !host_cmd_accept && !link_data_en && !sysclk_req)
    else $error("deep sleep left services running");
  AST_ANCHOR_WAKE: assert property (
    lp_ff == LP_DEEP && anchor_due && deep_ok && !any_wake
    |=> lp_ff == LP_DEEP_XCHG ##1 sysclk_req)
    else $error("anchor did not wake deep sleep");
  AST_HOST_WAKE: assert property (
    lp_ff == LP_DEEP && host_wake |=> lp_ff == LP_SLEEP ##1 host_cmd_accept)
    else $error("host wake did not reach sleep");
  AST_RATE_32K: assert property (
    slow_rise && per_cnt_ff == FAST_P |=> slow_rate == SLOW_EXT32)
    else $error("32 kHz slow clock not detected");

  COV_ROM_DOWNLOAD: cover property (@(posedge clk) disable iff (sys_rst)
    boot_ff == BOOT_ROM_WATCH ##1 boot_ff == BOOT_ROM_LOAD);
  COV_DEEP_XCHG: cover property (@(posedge clk) disable iff (sys_rst)
    lp_ff == LP_DEEP_XCHG ##1 lp_ff == LP_DEEP);
  COV_DEEP_TO_SLEEP: cover property (@(posedge clk) disable iff (sys_rst)
    lp_ff == LP_DEEP ##1 lp_ff == LP_SLEEP);
  COV_EXT3K2: cover property (@(posedge clk) disable iff (sys_rst)
    slow_src == SRC_EXT3K2);

endmodule : brlp_ctrl

//--- verification/brlp_host_model.sv
// host processor model on the far side of the serial host link
// assumes the bench calls its tasks; it drives on the falling edge
`timescale 1ns/1ps
module brlp_host_model (
  input wire logic clk,
  output logic host_serial_rx_in,
  output logic host_link_lowpower_in
);
  // idle line is high, as a pulled-up receive line would be
  initial begin
    host_serial_rx_in = 1'b1;
    host_link_lowpower_in = 1'b0;
  end

  // park the host link so the device may choose deep sleep
  task automatic link_sleep();
    @(negedge clk);
    host_link_lowpower_in = 1'b1;
  endtask : link_sleep

  // reactivate: leave low power and, on the same edge, begin a start bit of gap cycles
  task automatic link_wake(input int gap);
    @(negedge clk);
    host_link_lowpower_in = 1'b0;
    host_serial_rx_in = 1'b0;
    repeat (gap) @(negedge clk);
    host_serial_rx_in = 1'b1;
  endtask : link_wake
endmodule : brlp_host_model

//--- verification/tb_boot_reset_low_power_control.sv
// self-checking bench for the boot, reset and low-power controller
// assumes a shortened boot watch and absence count set below
`timescale 1ns/1ps
module tb_boot_reset_low_power_control;
  import brlp_pkg::*;
  localparam int WATCH = 50;
  localparam int ABSENT = 8000;
  // 3.2 kHz stand-in period, scaled so the bench stays short
  localparam int LOWP = 6000;
  localparam int TW = 8000;
  logic clk, sys_rst, boot_strap_in, download_req_in, download_done_in;
  logic debug_tx_data_in, host_tx_data_in, debug_serial_rx_in;
  logic ext_irq_line_a, ext_irq_line_b, usb_wake_in, slow_clk_in;
  logic [GPIO_N-1:0] gpio_in, gpio_wake_en_in, gpio_irq_en_in, gpio_irq;
  logic xtal_clk_in, sysclk_always_on_in, usb_transport_in;
  logic link_active_in, sniff_park_in, scan_enabled_in, sched_idle_in;
  logic exchange_done_in, slow_run;
  logic [15:0] anchor_interval_in;
  logic host_serial_rx_in, host_link_lowpower_in;
  logic debug_serial_tx_out, debug_serial_tx_oe, host_serial_tx_out;
  logic host_serial_tx_oe, fetch_en, run_from_flash, run_from_rom;
  logic slow_tick, sleep_mode, deep_sleep_mode, sysclk_req, core_clk_en;
  logic host_cmd_accept, link_data_en;
  brlp_rate_e slow_rate;
  brlp_src_e slow_src;
  int mismatches = 0;
  int compares = 0;
  int ticks = 0;
  int irqs = 0;
  int half = 15630;

  brlp_ctrl #(.BOOT_WATCH_CYC(WATCH), .SLOW_LOW_CYC(LOWP),
    .SLOW_ABSENT_CYC(ABSENT)) i_dut (
    .clk, .sys_rst, .boot_strap_in, .download_req_in, .download_done_in,
    .debug_tx_data_in, .host_tx_data_in, .debug_serial_rx_in,
    .host_serial_rx_in, .ext_irq_line_a, .ext_irq_line_b, .usb_wake_in,
    .gpio_in, .gpio_wake_en_in, .gpio_irq_en_in, .slow_clk_in,
    .xtal_clk_in, .sysclk_always_on_in, .usb_transport_in,
    .link_active_in, .sniff_park_in, .scan_enabled_in, .sched_idle_in,
    .host_link_lowpower_in, .exchange_done_in, .anchor_interval_in,
    .debug_serial_tx_out, .debug_serial_tx_oe, .host_serial_tx_out,
    .host_serial_tx_oe, .fetch_en, .run_from_flash, .run_from_rom,
    .slow_rate, .slow_src, .slow_tick, .gpio_irq, .sleep_mode,
    .deep_sleep_mode, .sysclk_req, .core_clk_en, .host_cmd_accept,
    .link_data_en);

  brlp_host_model i_host (.clk, .host_serial_rx_in, .host_link_lowpower_in);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // slow sources: half period in ns, 3126 cycles a period by default so
  // a rise meets the nominal count; edges land on falling clock edges
  initial begin
    forever begin
      #(half);
      slow_clk_in = slow_run ? ~slow_clk_in : 1'b0;
      xtal_clk_in = ~xtal_clk_in;
    end
  end

  // pulse counters, so short pulses are never missed by polling
  always @(posedge clk) begin
    if (slow_tick === 1'b1) ticks++;
    if (gpio_irq[3] === 1'b1) irqs++;
  end

  task automatic check_bit(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : check_bit

  task automatic check_two(input string nm, input logic [1:0] e,
                           input logic [1:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : check_two

  function automatic logic get_sig(input int sel);
    case (sel)
      0: return sleep_mode;
      1: return deep_sleep_mode;
      2: return sysclk_req;
      3: return run_from_flash;
      4: return slow_rate === SLOW_EXT32;
      5: return slow_src === SRC_XTAL;
      default: return slow_src === SRC_DIV;
    endcase
  endfunction : get_sig

  // bounded wait; running out is a mismatch and ends the run
  task automatic wait_sig(input int sel, input logic v, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      if (get_sig(sel) === v) return;
    end
    mismatches++;
    $display("mismatch wait_%0d expected %b seen timeout", sel, v);
    print_verdict();
  endtask : wait_sig

  // reset held 6 cycles, a scaled stand-in for the system minimum
  task automatic apply_reset(input logic strap, input logic on);
    @(negedge clk);
    sys_rst = 1'b1;
    boot_strap_in = strap;
    sysclk_always_on_in = on;
    repeat (6) @(negedge clk);
    check_bit("host_tx_oe", 1'b0, host_serial_tx_oe);
    check_bit("debug_tx_oe", 1'b0, debug_serial_tx_oe);
    sys_rst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : apply_reset

  task automatic t_boot_flash();
    apply_reset(1'b1, 1'b0);
    check_bit("run_from_flash", 1'b1, run_from_flash);
    check_bit("run_from_rom", 1'b0, run_from_rom);
    check_bit("fetch_en", 1'b1, fetch_en);
    check_bit("host_tx_oe", 1'b1, host_serial_tx_oe);
    @(negedge clk);
    boot_strap_in = 1'b0;
    host_tx_data_in = 1'b0;
    repeat (WATCH + 10) @(negedge clk);
    check_bit("run_from_flash", 1'b1, run_from_flash);
    check_bit("host_tx_out", 1'b0, host_serial_tx_out);
    check_bit("debug_tx_out", 1'b1, debug_serial_tx_out);
    host_tx_data_in = 1'b1;
  endtask : t_boot_flash

  task automatic t_boot_rom(input logic load);
    apply_reset(1'b0, 1'b0);
    check_bit("run_from_rom", 1'b1, run_from_rom);
    check_bit("run_from_flash", 1'b0, run_from_flash);
    @(negedge clk);
    boot_strap_in = 1'b1;
    download_req_in = load;
    @(negedge clk);
    download_req_in = 1'b0;
    repeat (load ? WATCH + 20 : WATCH - 5) @(negedge clk);
    check_bit("run_from_rom", 1'b1, run_from_rom);
    download_done_in = load;
    wait_sig(3, 1'b1, 20);
    download_done_in = 1'b0;
    check_bit("run_from_rom", 1'b0, run_from_rom);
  endtask : t_boot_rom

  // an external 32 kHz clock, then its removal
  task automatic t_slow_ext();
    apply_reset(1'b1, 1'b0);
    slow_run = 1'b1;
    wait_sig(4, 1'b1, 10000);
    repeat (2) @(negedge clk);
    check_two("slow_src", SRC_EXT32, slow_src);
    slow_run = 1'b0;
    wait_sig(5, 1'b1, ABSENT + 4000);
    check_two("slow_rate", SLOW_NONE, slow_rate);
    // a slow clock at the scaled 3.2 kHz period
    half = LOWP * 5;
    slow_run = 1'b1;
    repeat (15000) @(negedge clk);
    check_two("slow_rate", SLOW_EXT3K2, slow_rate);
    check_two("slow_src", SRC_EXT3K2, slow_src);
    slow_run = 1'b0;
    half = 15630;
  endtask : t_slow_ext

  task automatic pulse_wake(input int i);
    @(negedge clk);
    case (i)
      0: ext_irq_line_a = 1'b1;
      1: ext_irq_line_b = 1'b1;
      2: usb_wake_in = 1'b1;
      3: debug_serial_rx_in = 1'b0;
      default: gpio_in[3] = ~gpio_in[3];
    endcase
    @(negedge clk);
    ext_irq_line_a = 1'b0;
    ext_irq_line_b = 1'b0;
    usb_wake_in = 1'b0;
    debug_serial_rx_in = 1'b1;
  endtask : pulse_wake

  // divider source, then sleep, deep sleep, anchors and wake-ups
  task automatic t_modes();
    apply_reset(1'b1, 1'b1);
    wait_sig(6, 1'b1, ABSENT + 4000);
    sched_idle_in = 1'b1;
    ticks = 0;
    wait_sig(0, 1'b1, TW);
    check_bit("tick_seen", 1'b1, ticks != 0);
    check_bit("cmd_accept", 1'b1, host_cmd_accept);
    check_bit("link_data_en", 1'b1, link_data_en);
    usb_transport_in = 1'b1;
    i_host.link_sleep();
    repeat (TW) @(negedge clk);
    check_bit("deep", 1'b0, deep_sleep_mode);
    usb_transport_in = 1'b0;
    link_active_in = 1'b1;
    repeat (TW) @(negedge clk);
    check_bit("deep", 1'b0, deep_sleep_mode);
    check_bit("sleep", 1'b1, sleep_mode);
    link_active_in = 1'b0;
    wait_sig(1, 1'b1, TW);
    check_bit("cmd_accept", 1'b0, host_cmd_accept);
    check_bit("link_data_en", 1'b0, link_data_en);
    check_bit("sysclk_req", 1'b0, sysclk_req);
    sniff_park_in = 1'b1;
    anchor_interval_in = 16'h0002;
    wait_sig(2, 1'b1, 10000);
    check_bit("core_clk_en", 1'b1, core_clk_en);
    check_bit("cmd_accept", 1'b0, host_cmd_accept);
    exchange_done_in = 1'b1;
    @(negedge clk);
    exchange_done_in = 1'b0;
    wait_sig(2, 1'b0, 20);
    check_bit("deep", 1'b1, deep_sleep_mode);
    sniff_park_in = 1'b0;
    anchor_interval_in = 16'h0000;
    i_host.link_wake(4);
    wait_sig(1, 1'b0, 20);
    wait_sig(0, 1'b1, TW);
    gpio_wake_en_in = 16'h0008;
    gpio_irq_en_in = 16'h0008;
    for (int i = 0; i < 5; i++) begin
      pulse_wake(i);
      wait_sig(0, 1'b0, 20);
      wait_sig(0, 1'b1, TW);
    end
    check_bit("gpio_irq_once", 1'b1, irqs == 1);
  endtask : t_modes

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // every input valued at time zero, scan and uart data held idle
  initial begin
    sys_rst = 1'b1;
    {boot_strap_in, download_req_in, download_done_in} = 3'b100;
    {debug_tx_data_in, host_tx_data_in, debug_serial_rx_in} = 3'b111;
    {ext_irq_line_a, ext_irq_line_b, usb_wake_in} = 3'b000;
    {slow_clk_in, xtal_clk_in, slow_run, sysclk_always_on_in} = 4'h0;
    {usb_transport_in, link_active_in, sniff_park_in} = 3'b000;
    {scan_enabled_in, sched_idle_in, exchange_done_in} = 3'b000;
    gpio_in = 16'h0000;
    gpio_wake_en_in = 16'h0000;
    gpio_irq_en_in = 16'h0000;
    anchor_interval_in = 16'h0000;
    t_boot_flash();
    t_boot_rom(1'b0);
    t_boot_rom(1'b1);
    t_slow_ext();
    t_modes();
    print_verdict();
  end
endmodule : tb_boot_reset_low_power_control
